// *** dsc_deser_out.sv ***
// Deserializer output state, lock, spread-spectrum and fallback clock control
//
// Function
// - Spread spectrum modulates both pixel clock and data outputs; strap or register.
// - Normal range: code selects deviation and rate PCLK/2168, 1300, 868, 650.
// - Low range: same deviations at PCLK/620, 370, 258, 192; zero is off.
// - Power-down input low tristates pixel clock, data, lock and pass.
// - Auto-detect: stream stop powers down; resumed stream relocks and drives data.
// - Entering power-down returns all software registers to reset values.
// - Missing embedded clock bits enter sleep; restart relocks and resumes.
// - Sleep leaves software register contents unchanged.
// - Power-down release starts locking; lock output leaves tristate driven low.
// - Lock done drives lock high and presents recovered data and clock.
// - Pixel clock source changeover holds present level, without glitch.
// - Embedded clock loss drives lock low; data follows idle output select.
// - Static input: select low drives all low, high tristates clock and data.
// - Absent clock with oscillator enabled: oscillator clock, data lock pass low.
// - Oscillator code zero disables; others pick 50 down to 6.3 MHz.
// - Oscillator frequency comes from strap pins or a register.
// - Straps sampled during power-up; open strap reads low.
`timescale 1ns/1ps
module dsc_deser_out import dsc_pkg::*; (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte select
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic power_down_n_i, // Power-down pin, low to power down
  input wire logic embedded_clk_i, // Embedded clock bit from the serial front end
  input wire dsc_cfg_s strap_cfg_i, // Configuration strap pins
  input wire logic strap_auto_pd_i, // Auto-detect power-down strap
  input wire logic [VID_W-1:0] rx_vid_i, // Recovered video word
  output logic pclk_o, // Pixel clock output
  output logic pclk_oe_o, // Pixel clock output enable
  output logic [VID_W-1:0] vid_o, // Parallel video and sync outputs
  output logic vid_oe_o, // Video output enable
  output logic lock_o, // Lock status
  output logic lock_oe_o, // Lock output enable
  output logic pass_o, // Pass status
  output logic pass_oe_o, // Pass output enable
  output logic irq_o // Interrupt, level
);

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] pd_sync_q;
  logic [2:0] ec_sync_q;
  dsc_cfg_s strap_s1_q;
  dsc_cfg_s strap_s2_q;
  logic apd_s1_q;
  logic apd_s2_q;
  logic pd;
  logic ec_edge;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_sync_q <= 2'h0;
      ec_sync_q <= 3'h0;
      strap_s1_q <= '0;
      strap_s2_q <= '0;
      apd_s1_q <= 1'b0;
      apd_s2_q <= 1'b0;
    end else begin
      pd_sync_q <= {pd_sync_q[0], power_down_n_i};
      ec_sync_q <= {ec_sync_q[1:0], embedded_clk_i};
      strap_s1_q <= strap_cfg_i;
      strap_s2_q <= strap_s1_q;
      apd_s1_q <= strap_auto_pd_i;
      apd_s2_q <= apd_s1_q;
    end
  end

  assign pd = pd_sync_q[1];
  assign ec_edge = ec_sync_q[2] ^ ec_sync_q[1];

  ////////////////////////////////////////////////////////////////
  // Embedded clock activity
  logic [CNT_W-1:0] quiet_q;
  logic present_q;
  logic stop_ev;

  assign stop_ev = present_q && !ec_edge && quiet_q == STOP_LAST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quiet_q <= '0;
      present_q <= 1'b0;
    end else if (ec_edge) begin
      quiet_q <= '0;
      present_q <= 1'b1;
    end else if (quiet_q == STOP_LAST) begin
      present_q <= 1'b0;
    end else begin
      quiet_q <= quiet_q + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Power and lock sequencing
  dsc_state_e state_q;
  dsc_state_e state_d;
  logic [CNT_W-1:0] lock_cnt_q;
  dsc_cfg_s strap_q;
  logic auto_pd_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_PWRDN: begin
        if (pd && (!auto_pd_q || present_q)) begin
          state_d = ST_LOCKING;
        end
      end
      ST_SLEEP: begin
        if (present_q) begin
          state_d = ST_LOCKING;
        end
      end
      ST_LOCKING: begin
        if (lock_cnt_q == LOCK_LAST) begin
          state_d = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        state_d = ST_LOCKED;
      end
    endcase
    if (state_q != ST_PWRDN) begin
      if (!pd) begin
        state_d = ST_PWRDN;
      end else if (!present_q) begin
        state_d = auto_pd_q ? ST_PWRDN : ST_SLEEP;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_PWRDN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_LOCKING) begin
      lock_cnt_q <= '0;
    end else begin
      lock_cnt_q <= lock_cnt_q + CNT_W'(1);
    end
  end

  // Straps follow the pins while powered down, frozen once running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_q <= '0;
      auto_pd_q <= 1'b0;
    end else if (state_q == ST_PWRDN) begin
      strap_q <= strap_s2_q;
      auto_pd_q <= apd_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register file, cleared by power-down but not by sleep
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  dsc_cfg_s cfg_reg_q;
  dsc_cfg_s cfg;
  logic src_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  logic regs_clr;
  logic wb_hit;
  logic wb_wr;
  logic [31:0] ctrl_rd;
  logic [31:0] ctrl_wr;
  logic [31:0] en_wr;

  assign regs_clr = rst_i || state_q == ST_PWRDN;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i;
  assign ctrl_rd = {src_q, 22'h0, cfg_reg_q};
  assign ctrl_wr = merge(ctrl_rd, wb_dat_i, wb_sel_i);
  assign en_wr = merge({29'h0, irq_en_q}, wb_dat_i, wb_sel_i);
  assign cfg = src_q ? cfg_reg_q : strap_q;

  always_ff @(posedge clk_i) begin
    if (regs_clr) begin
      cfg_reg_q <= '0;
      src_q <= 1'b0;
      irq_en_q <= '0;
    end else if (wb_wr && wb_adr_i == REG_CTRL) begin
      cfg_reg_q <= ctrl_wr[CFG_W-1:0];
      src_q <= ctrl_wr[CTRL_SRC_BIT];
    end else if (wb_wr && wb_adr_i == REG_IRQ_ENABLE) begin
      irq_en_q <= en_wr[IRQ_W-1:0];
    end
  end

  assign irq_ev[IRQ_LOCK_UP] = state_d == ST_LOCKED && state_q != ST_LOCKED;
  assign irq_ev[IRQ_LOCK_LOST] = state_q == ST_LOCKED && state_d != ST_LOCKED;
  assign irq_ev[IRQ_STREAM_STOP] = stop_ev;
  assign irq_clr = (wb_wr && wb_adr_i == REG_IRQ_CLEAR && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0;

  // New events win over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (regs_clr) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
    end
  end

  assign irq_o = |(irq_st_q & irq_en_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= ctrl_rd;
          REG_STATUS: wb_dat_o <= {28'h0, state_q, present_q, lock_o};
          REG_IRQ_STATUS: wb_dat_o <= {29'h0, irq_st_q};
          REG_IRQ_ENABLE: wb_dat_o <= {29'h0, irq_en_q};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Spread-spectrum pixel clock: triangle-swept phase accumulator
  dsc_ssc_s ssc;
  logic [3:0] code_m1;
  logic [8:0] dev;
  logic [10:0] tri_q;
  logic tri_up_q;
  logic [21:0] tri_prod;
  logic [18:0] dev_prod;
  logic [NCO_W-1:0] inc;
  logic [NCO_W-1:0] acc_q;
  logic [NCO_W:0] acc_sum;
  logic ssc_clk_q;
  logic pix_rise;
  logic locked;

  assign locked = state_q == ST_LOCKED;
  assign code_m1 = cfg.spread_code - 4'h1;
  assign ssc = ssc_param(cfg.low_freq_range_sel, code_m1[3:2]);
  assign dev = ssc_dev(code_m1[1:0]);
  assign tri_prod = 22'(tri_q * ssc.recip);
  assign dev_prod = 19'(dev * tri_prod[17:8]);
  // Quantised sweep; the rate stays exact, the peak deviation is within one step
  assign inc = (cfg.spread_code == 4'h0) ? NOM_INC :
               NCO_W'(NOM_INC + {6'h0, dev_prod[17:8]} - {7'h0, dev});
  assign acc_sum = {1'b0, acc_q} + {1'b0, inc};
  assign pix_rise = locked && acc_sum[NCO_W] && !ssc_clk_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !locked) begin
      acc_q <= '0;
      ssc_clk_q <= 1'b0;
    end else begin
      acc_q <= acc_sum[NCO_W-1:0];
      if (acc_sum[NCO_W]) begin
        ssc_clk_q <= ~ssc_clk_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || cfg.spread_code == 4'h0 || tri_q > ssc.half) begin
      tri_q <= 11'h0;
      tri_up_q <= 1'b1;
    end else if (pix_rise) begin
      if (tri_up_q) begin
        tri_q <= tri_q + 11'h1;
        tri_up_q <= (tri_q + 11'h1) != ssc.half;
      end else begin
        tri_q <= tri_q - 11'h1;
        tri_up_q <= tri_q == 11'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output states
  logic use_osc;

  assign use_osc = cfg.fallback_osc_freq_sel != 3'h0 && !present_q &&
                   (state_q == ST_SLEEP || state_q == ST_LOCKING);

  dsc_pclk_switch u_pclk_switch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .osc_sel_i(cfg.fallback_osc_freq_sel),
    .use_osc_i(use_osc),
    .ssc_clk_i(ssc_clk_q),
    .pclk_o(pclk_o)
  );

  // Video words move only on modulated pixel edges, so data spreads too
  always_ff @(posedge clk_i) begin
    if (rst_i || !locked) begin
      vid_o <= '0;
    end else if (pix_rise) begin
      vid_o <= rx_vid_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {pclk_oe_o, vid_oe_o, lock_oe_o, pass_oe_o, lock_o, pass_o} <= 6'h0;
    end else begin
      unique case (state_q)
        ST_PWRDN: begin
          {pclk_oe_o, vid_oe_o, lock_oe_o, pass_oe_o, lock_o, pass_o} <= 6'h0;
        end
        ST_LOCKED: begin
          {pclk_oe_o, vid_oe_o, lock_oe_o, pass_oe_o, lock_o, pass_o} <= 6'h3f;
        end
        default: begin
          lock_oe_o <= 1'b1;
          pass_oe_o <= 1'b1;
          lock_o <= 1'b0;
          pass_o <= 1'b0;
          pclk_oe_o <= use_osc || !cfg.idle_output_state_sel;
          vid_oe_o <= use_osc || !cfg.idle_output_state_sel;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_lock_done;
    state_q == ST_LOCKING && lock_cnt_q == LOCK_LAST && pd && present_q;
  endsequence

  sequence seq_locked_out;
    lock_o && lock_oe_o && pass_o && vid_oe_o && pclk_oe_o;
  endsequence

  a_pd_outputs_off: assert property (state_q == ST_PWRDN |=>
    !(pclk_oe_o || vid_oe_o || lock_oe_o || pass_oe_o))
    else $error("output driven during power-down");

  a_pd_regs_clear: assert property (state_q == ST_PWRDN |=>
    cfg_reg_q == '0 && !src_q && irq_en_q == '0 && irq_st_q == '0)
    else $error("registers not cleared by power-down");

  a_sleep_keeps_cfg: assert property (state_q == ST_SLEEP && !(wb_wr && wb_adr_i == REG_CTRL) |=>
    $stable(cfg_reg_q) && $stable(src_q))
    else $error("sleep disturbed configuration");

  a_pdn_rise_lock: assert property (state_q == ST_PWRDN && pd && !auto_pd_q |=>
    state_q == ST_LOCKING ##1 lock_oe_o && !lock_o)
    else $error("lock not driven low after power-down release");

  a_lock_after_seq: assert property (seq_lock_done |=> state_q == ST_LOCKED ##1 seq_locked_out)
    else $error("lock not raised after lock sequence");

  a_loss_drops_lock: assert property (state_q == ST_LOCKED && pd && !present_q |=>
    state_q != ST_LOCKED ##1 !lock_o)
    else $error("lock held after loss of embedded clock");

  a_stop_to_sleep: assert property (state_q == ST_LOCKED && pd && !auto_pd_q && stop_ev |=>
    ##1 state_q == ST_SLEEP)
    else $error("stopped stream did not enter sleep");

  a_auto_pd: assert property (state_q == ST_LOCKED && pd && auto_pd_q && stop_ev |=>
    ##1 state_q == ST_PWRDN ##1 !lock_oe_o)
    else $error("auto-detect did not power down on stream stop");

  a_oss_static_low: assert property (state_q == ST_SLEEP && !use_osc && !cfg.idle_output_state_sel |=>
    pclk_oe_o && vid_oe_o && vid_o == '0 && lock_oe_o && !lock_o && !pass_o)
    else $error("static input with select low not driven low");

  a_oss_static_tri: assert property (state_q == ST_SLEEP && !use_osc && cfg.idle_output_state_sel |=>
    !pclk_oe_o && !vid_oe_o && lock_oe_o && !lock_o && !pass_o)
    else $error("static input with select high not tristated");

  a_osc_fallback: assert property (state_q == ST_SLEEP && use_osc |=>
    pclk_oe_o && vid_oe_o && vid_o == '0 && !lock_o && !pass_o)
    else $error("oscillator fallback output state wrong");

  // The sweep counter clears on the edge after the code reaches zero
  a_ssc_off: assert property (cfg.spread_code == 4'h0 |-> inc == NOM_INC ##1 tri_q == 11'h0)
    else $error("modulation active with spread code zero");

endmodule

// *** dsc_pclk_switch.sv ***
// Fallback oscillator and glitch-free pixel clock output selector
`timescale 1ns/1ps
module dsc_pclk_switch import dsc_pkg::*; (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [2:0] osc_sel_i, // Oscillator frequency code
  input wire logic use_osc_i, // Request oscillator as source
  input wire logic ssc_clk_i, // Modulated recovered clock level
  output logic pclk_o // Pixel clock output level
);

  logic [3:0] osc_cnt_q;
  logic osc_q;
  logic cur_q;
  logic src_lvl;

  ////////////////////////////////////////////////////////////////
  // Oscillator divider, stopped while disabled
  always_ff @(posedge clk_i) begin
    if (rst_i || osc_sel_i == 3'h0) begin
      osc_cnt_q <= 4'h0;
      osc_q <= 1'b0;
    end else if (osc_cnt_q >= osc_half(osc_sel_i) - 4'h1) begin
      osc_cnt_q <= 4'h0;
      osc_q <= ~osc_q;
    end else begin
      osc_cnt_q <= osc_cnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Switch only once the new source sits at the held level
  assign src_lvl = use_osc_i ? osc_q : ssc_clk_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_q <= 1'b0;
      pclk_o <= 1'b0;
    end else if (use_osc_i != cur_q) begin
      if (src_lvl == pclk_o) begin
        cur_q <= use_osc_i;
      end
    end else begin
      pclk_o <= cur_q ? osc_q : ssc_clk_i;
    end
  end

  a_switch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    use_osc_i != cur_q |=> $stable(pclk_o))
    else $error("pixel clock moved during source changeover");

endmodule

// *** dsc_pkg.sv ***
// Shared constants, types and helpers for the deserializer output-state block
package dsc_pkg;

  // Clock and timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int STOP_TIME_NS = 1000;
  localparam int STOP_CYC = (STOP_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int LOCK_TIME_NS = 5000;
  localparam int LOCK_CYC = (LOCK_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] STOP_LAST = CNT_W'(STOP_CYC - 1);
  localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYC - 1);

  // Parallel video bus: 24 colour bits plus three sync bits
  localparam int VID_W = 27;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h0c;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
  localparam int CTRL_SRC_BIT = 31;
  localparam int CFG_W = 9;
  localparam int IRQ_LOCK_UP = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_STREAM_STOP = 2;
  localparam int IRQ_W = 3;

  // Spread-spectrum phase accumulator
  localparam int NCO_W = 16;
  localparam int NCO_NOM = 16384;
  localparam logic [NCO_W-1:0] NOM_INC = NCO_W'(NCO_NOM);
  localparam int DEV_STEP_PERMILLE = 5;
  localparam int SSC_RECIP_NUM = 262144;

  typedef enum logic [1:0] {
    ST_PWRDN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_LOCKING = 2'b10,
    ST_LOCKED = 2'b11
  } dsc_state_e;

  typedef struct packed {
    logic [3:0] spread_code;
    logic low_freq_range_sel;
    logic idle_output_state_sel;
    logic [2:0] fallback_osc_freq_sel;
  } dsc_cfg_s;

  typedef struct packed {
    logic [10:0] half;
    logic [10:0] recip;
  } dsc_ssc_s;

  function automatic dsc_ssc_s ssc_mk(input int div);
    ssc_mk.half = 11'(div / 2);
    ssc_mk.recip = 11'(SSC_RECIP_NUM / div);
  endfunction

  // Modulation period in pixel clocks per code group and range
  function automatic dsc_ssc_s ssc_param(input logic lf, input logic [1:0] grp);
    unique case ({lf, grp})
      3'b000: ssc_param = ssc_mk(2168);
      3'b001: ssc_param = ssc_mk(1300);
      3'b010: ssc_param = ssc_mk(868);
      3'b011: ssc_param = ssc_mk(650);
      3'b100: ssc_param = ssc_mk(620);
      3'b101: ssc_param = ssc_mk(370);
      3'b110: ssc_param = ssc_mk(258);
      3'b111: ssc_param = ssc_mk(192);
    endcase
  endfunction

  // Peak increment offset: 0.5, 1.0, 1.5, 2.0 percent
  function automatic logic [8:0] ssc_dev(input logic [1:0] idx);
    ssc_dev = 9'((NCO_NOM * (int'(idx) + 1) * DEV_STEP_PERMILLE + 500) / 1000);
  endfunction

  // Half period in clk_i cycles: 50, 25, 16.7, 12.5, 10, 8.3, 6.25 MHz
  function automatic logic [3:0] osc_half(input logic [2:0] sel);
    unique case (sel)
      3'h0: osc_half = 4'h0;
      3'h1: osc_half = 4'h1;
      3'h2: osc_half = 4'h2;
      3'h3: osc_half = 4'h3;
      3'h4: osc_half = 4'h4;
      3'h5: osc_half = 4'h5;
      3'h6: osc_half = 4'h6;
      3'h7: osc_half = 4'h8;
    endcase
  endfunction

endpackage

// *** dsc_ser_model.sv ***
// Serializer stand-in driving embedded clock bit and recovered video
`timescale 1ns/1ps
module dsc_ser_model import dsc_pkg::*; (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic run_i, // Stream running
  output logic emb_o, // Embedded clock bit level
  output logic [VID_W-1:0] vid_o // Recovered video word
);
  logic div_q;
  // A stopped stream leaves the bit static, as a dead link would
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 1'b0;
      emb_o <= 1'b0;
    end else begin
      div_q <= ~div_q;
      if (run_i && div_q) begin
        emb_o <= ~emb_o;
      end
    end
  end
  // Fresh word every cycle so stale data never looks valid
  always_ff @(posedge clk_i) begin
    vid_o <= VID_W'($urandom);
  end
endmodule

// *** tb_dsc_deser_out.sv ***
// Self-checking bench for the deserializer output-state block
`timescale 1ns/1ps
module tb_dsc_deser_out import dsc_pkg::*; ;
  logic clk_i, rst_i, run, pd_n, auto_pd, cyc, stb, we, ack, irq;
  logic pclk, pclk_oe, vid_oe, lock, lock_oe, pass, pass_oe;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [VID_W-1:0] rxv, vid, rx_d1, rx_d2;
  logic emb;
  logic [3:0] sc[3] = '{4'h0, 4'h4, 4'hc};
  dsc_cfg_s strap, cfg;
  int fail_count, n_compared, p;
  int cyc_n = 0;

  dsc_deser_out dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .power_down_n_i(pd_n), .embedded_clk_i(emb), .strap_cfg_i(strap), .strap_auto_pd_i(auto_pd),
    .rx_vid_i(rxv), .pclk_o(pclk), .pclk_oe_o(pclk_oe), .vid_o(vid), .vid_oe_o(vid_oe),
    .lock_o(lock), .lock_oe_o(lock_oe), .pass_o(pass), .pass_oe_o(pass_oe), .irq_o(irq));
  dsc_ser_model ser (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .emb_o(emb), .vid_o(rxv));

  // Word taken at the pixel edge, seen by the panel as pclk rises
  always @(posedge clk_i) begin
    rx_d1 <= rxv;
    rx_d2 <= rx_d1;
  end

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin
      fail_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One classic cycle; read data lands in q
  // A hung slave is caught by the run's cycle ceiling
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    chk(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_sig(input bit oe, input logic v);
    int n;
    n = 0;
    while ((oe ? lock_oe : lock) !== v && n < 900) begin
      @(posedge clk_i);
      n++;
    end
    chk(oe ? lock_oe : lock, v);
  endtask

  // Second rising edge to the third; the first absorbs the changeover
  task automatic per(output int c);
    logic pr;
    repeat (3) begin
      c = 0;
      do begin
        pr = pclk;
        @(posedge clk_i);
        c++;
      end while (!(pclk === 1'b1 && pr === 1'b0) && c < 60);
    end
  endtask

  // Periods off nominal; the first partial one may count
  task automatic sweep(output int odd);
    logic pr;
    int c;
    odd = 0;
    c = 0;
    pr = pclk;
    repeat (4000) begin
      @(posedge clk_i);
      c++;
      if (pclk === 1'b1 && pr === 1'b0) begin
        if (c != 8) odd++;
        c = 0;
        chk(vid, rx_d2);
      end
      pr = pclk;
    end
  endtask

  function automatic int osc_cyc(input int s);
    return (s == 7) ? 16 : 2 * s;
  endfunction

  ////////////////////////////////////////
  initial begin
    p = $urandom(32'hd1ea5e4b);
    fail_count = 0;
    n_compared = 0;
    rst_i = 1'b1;
    run = 1'b0;
    pd_n = 1'b0;
    auto_pd = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    strap = '0;
    strap.idle_output_state_sel = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({pclk_oe, vid_oe, lock_oe, pass_oe}, 4'h0);
    wb(1'b1, REG_CTRL, 32'h80000005);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h0);
    run <= 1'b1;
    pd_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({lock_oe, lock}, 2'b10);
    wait_sig(1'b0, 1'b1);
    chk({pass, pass_oe, pclk_oe, vid_oe}, 4'hf);
    cfg = dsc_cfg_s'($urandom);
    cfg.idle_output_state_sel = 1'b1;
    cfg.fallback_osc_freq_sel = 3'h0;
    cfg.spread_code = 4'h0;
    wb(1'b1, REG_CTRL, {1'b1, 22'h0, cfg});
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, {1'b1, 22'h0, cfg});
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, REG_IRQ_ENABLE, 32'h7);
    wb(1'b0, REG_IRQ_STATUS, 32'h0);
    chk(q, 32'h1);
    chk(irq, 1'b1);
    wb(1'b1, REG_IRQ_CLEAR, 32'h1);
    chk(irq, 1'b0);
    for (int i = 0; i < 3; i++) begin
      cfg.spread_code = sc[i];
      cfg.low_freq_range_sel = (i == 2);
      wb(1'b1, REG_CTRL, {1'b1, 22'h0, cfg});
      sweep(p);
      chk(32'(p > 2), 32'(sc[i] != 4'h0));
    end
    run <= 1'b0;
    wait_sig(1'b0, 1'b0);
    repeat (150) @(posedge clk_i);
    chk(irq, 1'b1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[3:2], 2'b01);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, {1'b1, 22'h0, cfg});
    chk({pclk_oe, vid_oe, lock_oe, lock, pass_oe, pass}, 6'b001010);
    wb(1'b1, REG_IRQ_ENABLE, 32'h0);
    chk(irq, 1'b0);
    for (int s = 1; s < 8; s++) begin
      cfg.fallback_osc_freq_sel = 3'(s);
      wb(1'b1, REG_CTRL, {1'b1, 22'h0, cfg});
      per(p);
      chk(p, osc_cyc(s));
      chk({pclk_oe, vid, lock}, {1'b1, 27'h0, 1'b0});
    end
    run <= 1'b1;
    wait_sig(1'b0, 1'b1);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, {1'b1, 22'h0, cfg});
    pd_n <= 1'b0;
    strap.idle_output_state_sel <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({pclk_oe, vid_oe, lock_oe, pass_oe}, 4'h0);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h0);
    run <= 1'b0;
    pd_n <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk({pclk_oe, pclk, vid_oe, lock_oe, lock, pass_oe, pass}, 7'b1011010);
    chk(vid, 27'h0);
    repeat (120) @(posedge clk_i);
    chk({pclk_oe, pclk, vid_oe, lock_oe, lock, pass_oe, pass}, 7'b1011010);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[3:2], 2'b01);
    pd_n <= 1'b0;
    auto_pd <= 1'b1;
    run <= 1'b1;
    repeat (6) @(posedge clk_i);
    pd_n <= 1'b1;
    wait_sig(1'b0, 1'b1);
    run <= 1'b0;
    wait_sig(1'b1, 1'b0);
    chk({pclk_oe, vid_oe, pass_oe}, 3'h0);
    run <= 1'b1;
    wait_sig(1'b0, 1'b1);
    wrap_up();
  end
endmodule
